// [hdl/rcs_reset_cause.sv]
// Reset cause recording, reset source enables and system reset sequencer
`timescale 1ns/10ps
module rcs_reset_cause (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   // Special-function register access
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr_en,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_rd_en,
   output logic      [7:0] sfr_rdata,
   // Reset sources
   input  wire logic       pin_reset_n_in,
   input  wire logic       watchdog_overflow,
   input  wire logic       flash_fault,
   input  wire logic       comparator_zero_out,
   input  wire logic       supply_ok,
   input  wire logic       supply_monitor_enable,
   input  wire logic       clock_activity,
   // Results
   output logic            system_reset,
   output logic            comparator_reset_enable,
   output logic            clock_loss_enable,
   output logic            supply_monitor_selected
);
   import rcs_pkg::*;

   // Synchroniser flops for pins and analog outputs
   logic       pin_sync_a_reg;
   logic       pin_sync_b_reg;
   logic       comp_sync_a_reg;
   logic       comp_sync_b_reg;
   logic       vdd_sync_a_reg;
   logic       vdd_sync_b_reg;

   // Control and status state
   rcs_state_t state_reg;
   rcs_state_t state_next;
   logic [7:0] hold_reg;
   logic [7:0] hold_next;
   logic [6:0] flags_reg;
   logic [6:0] flags_next;
   logic       sys_reset_reg;
   logic       sys_reset_next;
   logic       comp_en_reg;
   logic       comp_en_next;
   logic       clkloss_en_reg;
   logic       clkloss_en_next;
   logic       mon_sel_reg;
   logic       mon_sel_next;
   logic       soft_req_reg;
   logic       soft_req_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       clkloss_timeout;

   // Decoded bus strobes
   wire        addr_hit;
   wire        wr_hit;
   wire        rd_hit;

   // Individual reset requests
   wire        req_pin;
   wire        req_supply;
   wire        req_clkloss;
   wire        req_wdog;
   wire        req_comp;
   wire        req_flash;
   wire        req_soft;
   wire        any_req;
   wire [6:0]  cause_now;
   wire        hold_done;

   // Named decode of the run state and the write fields
   wire        in_run;
   wire        entry_now;
   wire        wr_comp_bit;
   wire        wr_clkloss_bit;
   wire        wr_select_bit;
   wire        wr_force_bit;

   // Reset pin is asynchronous: two flops before any logic reads it
   // Reset to the idle high level, so no false request after power-on
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_sync_a_reg <= 1'b1;
         pin_sync_b_reg <= 1'b1;
      end else begin
         pin_sync_a_reg <= pin_reset_n_in;
         pin_sync_b_reg <= pin_sync_a_reg;
      end
   end

   // Comparator output is analog and may change at any moment
   // Idle high, since the comparator asks for reset when low
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         comp_sync_a_reg <= 1'b1;
         comp_sync_b_reg <= 1'b1;
      end else begin
         comp_sync_a_reg <= comparator_zero_out;
         comp_sync_b_reg <= comp_sync_a_reg;
      end
   end

   // Supply status from the analog monitor, idle high
   // A short glitch shorter than one clock may be missed here
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         vdd_sync_a_reg <= 1'b1;
         vdd_sync_b_reg <= 1'b1;
      end else begin
         vdd_sync_a_reg <= supply_ok;
         vdd_sync_b_reg <= vdd_sync_a_reg;
      end
   end

   // Missing clock detector, armed only by its enable bit
   rcs_clock_loss_detector u_clock_loss (
      .ref_clk        (ref_clk),
      .reset_n        (reset_n),
      .enable         (clkloss_en_reg),
      .clock_activity (clock_activity),
      .timeout        (clkloss_timeout)
   );

   // Run state; a new system reset may only begin from here
   assign in_run    = (state_reg == RCS_RUN);
   assign entry_now = in_run && any_req;

   // Bus decode; core is held off during the reset pulse
   assign addr_hit = (sfr_addr == RCS_CAUSE_ADDR);
   assign wr_hit   = sfr_wr_en && addr_hit && in_run;
   assign rd_hit   = sfr_rd_en && addr_hit;

   // Write fields; reads never see these, only the stored causes
   assign wr_comp_bit    = sfr_wdata[RCS_BIT_COMP];
   assign wr_clkloss_bit = sfr_wdata[RCS_BIT_CLKLOSS];
   assign wr_select_bit  = sfr_wdata[RCS_BIT_POWER];
   assign wr_force_bit   = sfr_wdata[RCS_BIT_SOFT];

   assign req_pin     = !pin_sync_b_reg;
   assign req_supply  = supply_monitor_enable && mon_sel_reg && !vdd_sync_b_reg;
   assign req_clkloss = clkloss_en_reg && clkloss_timeout;
   assign req_wdog    = watchdog_overflow;
   assign req_comp    = comp_en_reg && !comp_sync_b_reg;
   assign req_flash   = flash_fault;
   assign req_soft    = soft_req_reg;

   assign any_req = req_pin || req_supply || req_clkloss || req_wdog
                    || req_comp || req_flash || req_soft;

   // one cause only, highest priority first
   assign cause_now = req_pin     ? 7'(1 << RCS_BIT_PIN)     :
                      req_supply  ? 7'(1 << RCS_BIT_POWER)   :
                      req_clkloss ? 7'(1 << RCS_BIT_CLKLOSS) :
                      req_wdog    ? 7'(1 << RCS_BIT_WDOG)    :
                      req_comp    ? 7'(1 << RCS_BIT_COMP)    :
                      req_flash   ? 7'(1 << RCS_BIT_FLASH)   :
                                    7'(1 << RCS_BIT_SOFT);

   // Pulse ends after its length, but never while the pin is still low
   assign hold_done = (hold_reg == RCS_HOLD_ZERO) && !req_pin;

   // Sequencer and cause latch
   always_comb begin
      state_next     = state_reg;
      hold_next      = hold_reg;
      flags_next     = flags_reg;
      sys_reset_next = sys_reset_reg;
      case (state_reg)
         RCS_RUN: begin
            if (any_req) begin
               state_next     = RCS_HOLD;
               hold_next      = RCS_HOLD_LAST;
               flags_next     = cause_now;
               sys_reset_next = 1'b1;
            end
         end
         RCS_HOLD: begin
            if (hold_done) begin
               state_next     = RCS_RUN;
               sys_reset_next = 1'b0;
            end else if (hold_reg != RCS_HOLD_ZERO) begin
               hold_next = 8'(hold_reg - 8'h01);
            end
         end
         default: begin
            state_next     = RCS_HOLD;
            hold_next      = RCS_HOLD_LAST;
            flags_next     = RCS_FLAGS_POR;
            sys_reset_next = 1'b1;
         end
      endcase
   end

   // Enables: written by software; comparator and clock-loss enables cleared by each new system reset, monitor select kept
   always_comb begin
      comp_en_next    = comp_en_reg;
      clkloss_en_next = clkloss_en_reg;
      mon_sel_next    = mon_sel_reg;
      soft_req_next   = 1'b0;
      // A new reset wins over a write in the same cycle
      if (entry_now) begin
         comp_en_next    = RCS_ENABLE_RESET;
         clkloss_en_next = RCS_ENABLE_RESET;
      end else if (wr_hit) begin
         comp_en_next    = wr_comp_bit;
         clkloss_en_next = wr_clkloss_bit;
         mon_sel_next    = wr_select_bit;
         soft_req_next   = wr_force_bit;
      end
   end

   assign rdata_next = rd_hit ? {1'b0, flags_reg} : RCS_RDATA_RESET;

   // power-on leaves only the power flag
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_reg <= RCS_FLAGS_POR;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Power-on starts in the hold state with a full count
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= RCS_HOLD;
         hold_reg  <= RCS_HOLD_LAST;
      end else begin
         state_reg <= state_next;
         hold_reg  <= hold_next;
      end
   end

   // System reset output, high from power-on until the count runs out
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sys_reset_reg <= 1'b1;
      end else begin
         sys_reset_reg <= sys_reset_next;
      end
   end

   // Comparator and detector enables; each new system reset clears them
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         comp_en_reg    <= RCS_ENABLE_RESET;
         clkloss_en_reg <= RCS_ENABLE_RESET;
      end else begin
         comp_en_reg    <= comp_en_next;
         clkloss_en_reg <= clkloss_en_next;
      end
   end

   // Monitor select survives system resets, only power-on clears it
   // Keeping it lets a supply dip after a soft reset still be caught
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mon_sel_reg <= RCS_ENABLE_RESET;
      end else begin
         mon_sel_reg <= mon_sel_next;
      end
   end

   // Forced request lives one cycle, so one write forces one reset
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         soft_req_reg <= 1'b0;
      end else begin
         soft_req_reg <= soft_req_next;
      end
   end

   // Read data stands one cycle, then returns to zero
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= RCS_RDATA_RESET;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // All outputs straight from flops
   assign sfr_rdata               = rdata_reg;
   assign system_reset            = sys_reset_reg;
   assign comparator_reset_enable = comp_en_reg;
   assign clock_loss_enable       = clkloss_en_reg;
   assign supply_monitor_selected = mon_sel_reg;
endmodule

// [hdl/rcs_pkg.sv]
// Package with constants and types for the reset cause and source enable block
package rcs_pkg;

   // Register address on the special-function bus
   localparam logic [7:0] RCS_CAUSE_ADDR     = 8'hEF;

   // Bit positions inside the cause register
   localparam int         RCS_BIT_RESERVED   = 7;
   localparam int         RCS_BIT_FLASH      = 6;
   localparam int         RCS_BIT_COMP       = 5;
   localparam int         RCS_BIT_SOFT       = 4;
   localparam int         RCS_BIT_WDOG       = 3;
   localparam int         RCS_BIT_CLKLOSS    = 2;
   localparam int         RCS_BIT_POWER      = 1;
   localparam int         RCS_BIT_PIN        = 0;

   // Values after power-on reset
   localparam logic [6:0] RCS_FLAGS_POR      = 7'h02;
   localparam logic [7:0] RCS_RDATA_RESET    = 8'h00;
   localparam logic       RCS_ENABLE_RESET   = 1'b0;

   // Length of the system reset pulse
   localparam int         RCS_CLK_PERIOD_NS  = 10;
   localparam int         RCS_HOLD_NS        = 200;
   localparam int         RCS_HOLD_CYCLES    = (RCS_HOLD_NS + RCS_CLK_PERIOD_NS - 1)
                                               / RCS_CLK_PERIOD_NS;
   localparam logic [7:0] RCS_HOLD_LAST      = 8'(RCS_HOLD_CYCLES - 1);
   localparam logic [7:0] RCS_HOLD_ZERO      = 8'h00;

   // Clock-loss timeout, longest time so rounded down
   localparam int         RCS_CLKLOSS_NS     = 500;
   localparam int         RCS_CLKLOSS_CYCLES = RCS_CLKLOSS_NS / RCS_CLK_PERIOD_NS;
   localparam logic [7:0] RCS_CLKLOSS_LAST   = 8'(RCS_CLKLOSS_CYCLES - 1);
   localparam logic [7:0] RCS_CLKLOSS_ZERO   = 8'h00;

   // Sequencer states
   typedef enum logic [0:0] {
      RCS_RUN,
      RCS_HOLD
   } rcs_state_t;

endpackage

// [hdl/rcs_clock_loss_detector.sv]
// Missing clock detector watching a toggle from the monitored clock
`timescale 1ns/10ps
module rcs_clock_loss_detector (
   input  wire logic ref_clk,
   input  wire logic reset_n,
   input  wire logic enable,
   input  wire logic clock_activity,
   output logic      timeout
);
   import rcs_pkg::*;

   logic       sync_a_reg;
   logic       sync_b_reg;
   logic       seen_reg;
   logic       timeout_reg;
   logic       timeout_next;
   logic [7:0] count_reg;
   logic [7:0] count_next;
   wire        toggle_seen;
   wire        expired;

   // Activity comes from another clock: two flops before use
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync_a_reg <= 1'b0;
         sync_b_reg <= 1'b0;
         seen_reg   <= 1'b0;
      end else begin
         sync_a_reg <= clock_activity;
         sync_b_reg <= sync_a_reg;
         seen_reg   <= sync_b_reg;
      end
   end

   // Any edge of the toggle proves the clock still runs
   assign toggle_seen = sync_b_reg ^ seen_reg;
   assign expired     = enable && !toggle_seen && (count_reg == RCS_CLKLOSS_LAST);

   assign count_next   = (!enable || toggle_seen || expired) ? RCS_CLKLOSS_ZERO
                                                             : 8'(count_reg + 8'h01);
   assign timeout_next = expired;

   // Counter and one-cycle timeout pulse
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg   <= RCS_CLKLOSS_ZERO;
         timeout_reg <= 1'b0;
      end else begin
         count_reg   <= count_next;
         timeout_reg <= timeout_next;
      end
   end

   assign timeout = timeout_reg;
endmodule

// [verif/rcs_reset_cause_assertions.sv]
// Checker for the reset cause block ports
`timescale 1ns/10ps
module rcs_reset_cause_assertions
   import rcs_pkg::*;
(
   input wire logic       ref_clk,
   input wire logic       reset_n,
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr_en,
   input wire logic [7:0] sfr_wdata,
   input wire logic       sfr_rd_en,
   input wire logic [7:0] sfr_rdata,
   input wire logic       watchdog_overflow,
   input wire logic       flash_fault,
   input wire logic       system_reset,
   input wire logic       comparator_reset_enable,
   input wire logic       clock_loss_enable,
   input wire logic       supply_monitor_selected
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // Accepted write, no same-cycle pulse source
   logic wr_ok;
   assign wr_ok = sfr_wr_en && sfr_addr == RCS_CAUSE_ADDR && !system_reset;
   sequence soft_req_s;
      wr_ok && sfr_wdata[RCS_BIT_SOFT];
   endsequence
   sequence entry_s;
      $rose(system_reset);
   endsequence
   sequence quiet_wr_s;
      wr_ok && !sfr_wdata[RCS_BIT_SOFT] && !watchdog_overflow && !flash_fault;
   endsequence
   soft_force_a: assert property (soft_req_s |-> ##2 system_reset)
      else $error("soft write gave no reset");
   wdog_reset_a: assert property (watchdog_overflow && !system_reset |=> system_reset)
      else $error("watchdog gave no reset");
   flash_reset_a: assert property (flash_fault && !system_reset |=> system_reset)
      else $error("flash fault gave no reset");
   reset_hold_a: assert property (entry_s |=> system_reset[*8])
      else $error("system reset too short");
   enable_clear_a: assert property (entry_s |=> !comparator_reset_enable && !clock_loss_enable)
      else $error("enables kept over reset");
   comp_enable_a: assert property (quiet_wr_s ##0 sfr_wdata[5] |=> comparator_reset_enable)
      else $error("comparator enable not set");
   clk_enable_a: assert property (quiet_wr_s ##0 sfr_wdata[2] |=> clock_loss_enable)
      else $error("clock loss enable not set");
   sup_select_a: assert property (wr_ok && sfr_wdata[1] && !watchdog_overflow && !flash_fault
      |=> supply_monitor_selected)
      else $error("supply select not set");
   read_reserved_a: assert property (sfr_rd_en && sfr_addr == RCS_CAUSE_ADDR |=> !sfr_rdata[7])
      else $error("reserved bit reads one");
   read_other_a: assert property (sfr_rd_en && sfr_addr != RCS_CAUSE_ADDR |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule
bind rcs_reset_cause rcs_reset_cause_assertions u_rcs_reset_cause_assertions (
   .ref_clk(ref_clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
   .sfr_wdata(sfr_wdata), .sfr_rd_en(sfr_rd_en), .sfr_rdata(sfr_rdata),
   .watchdog_overflow(watchdog_overflow), .flash_fault(flash_fault),
   .system_reset(system_reset), .comparator_reset_enable(comparator_reset_enable),
   .clock_loss_enable(clock_loss_enable), .supply_monitor_selected(supply_monitor_selected));

// [verif/rcs_source_model.sv]
// Behavioural model of the on-chip reset sources
`timescale 1ns/10ps
module rcs_source_model (
   input  wire logic ref_clk,
   output logic      pin_reset_n_in,
   output logic      watchdog_overflow,
   output logic      flash_fault,
   output logic      comparator_zero_out,
   output logic      supply_ok,
   output logic      clock_activity
);
   logic clk_run = 1'b1;
   // Idle levels: no source asks for reset
   initial begin
      pin_reset_n_in = 1'b1;
      watchdog_overflow = 1'b0;
      flash_fault = 1'b0;
      comparator_zero_out = 1'b1;
      supply_ok = 1'b1;
      clock_activity = 1'b0;
   end
   // Monitored clock image, stops dead when halted
   always @(posedge ref_clk) if (clk_run) clock_activity <= ~clock_activity;
   // Raise one cause; clock halt outlasts the loss timeout
   task automatic fire(input int c);
      @(posedge ref_clk);
      #1;
      case (c)
         0: pin_reset_n_in = 1'b0;
         1: supply_ok = 1'b0;
         2: clk_run = 1'b0;
         3: watchdog_overflow = 1'b1;
         5: comparator_zero_out = 1'b0;
         6: flash_fault = 1'b1;
         default: ;
      endcase
      @(posedge ref_clk);
      #1;
      watchdog_overflow = 1'b0;
      flash_fault = 1'b0;
      repeat (c == 2 ? 56 : 4) @(posedge ref_clk);
      #1;
      pin_reset_n_in = 1'b1;
      supply_ok = 1'b1;
      clk_run = 1'b1;
      comparator_zero_out = 1'b1;
   endtask
endmodule

// [verif/rcs_reset_cause_tb.sv]
// Self-checking bench for the reset cause block
`timescale 1ns/10ps
module rcs_reset_cause_tb;
   import rcs_pkg::*;
   logic ref_clk = 1'b0, reset_n = 1'b0, sfr_wr_en = 1'b0, sfr_rd_en = 1'b0, mon_en = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, q, a, d;
   logic pin_n, wdog, flash, comp, sup_ok, act, sys_rst, comp_en, clk_en, sup_sel;
   logic [2:0] prev;
   int n_errors = 0, num_checks = 0;
   initial forever #5 ref_clk = ~ref_clk;
   rcs_reset_cause u_rcs_reset_cause (.ref_clk(ref_clk), .reset_n(reset_n),
      .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_wdata(sfr_wdata),
      .sfr_rd_en(sfr_rd_en), .sfr_rdata(sfr_rdata), .pin_reset_n_in(pin_n),
      .watchdog_overflow(wdog), .flash_fault(flash), .comparator_zero_out(comp),
      .supply_ok(sup_ok), .supply_monitor_enable(mon_en), .clock_activity(act),
      .system_reset(sys_rst), .comparator_reset_enable(comp_en),
      .clock_loss_enable(clk_en), .supply_monitor_selected(sup_sel));
   rcs_source_model u_rcs_source_model (.ref_clk(ref_clk), .pin_reset_n_in(pin_n),
      .watchdog_overflow(wdog), .flash_fault(flash), .comparator_zero_out(comp),
      .supply_ok(sup_ok), .clock_activity(act));
   task automatic final_report;
      if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
      num_checks++;
      if ((got & mask) !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One-cycle strobes, driven just after the edge
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge ref_clk);
      #1 {sfr_addr, sfr_wdata, sfr_wr_en} = {ad, dt, 1'b1};
      @(posedge ref_clk);
      #1 sfr_wr_en = 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
      @(posedge ref_clk);
      #1 {sfr_addr, sfr_rd_en} = {ad, 1'b1};
      @(posedge ref_clk);
      #1 sfr_rd_en = 1'b0;
      dt = sfr_rdata;
   endtask
   // Bounded wait for the reset pulse to end
   task automatic wait_rst;
      int i;
      for (i = 0; i < 200 && sys_rst !== 1'b0; i++) begin
         @(posedge ref_clk);
         #1;
      end
      if (i == 200) begin
         n_errors++;
         $display("CHECK FAILED t=%0t reset stuck", $time);
         final_report;
      end
   endtask
   initial begin
      void'($urandom(53290));
      repeat (2) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      wait_rst;
      rd(RCS_CAUSE_ADDR, q);
      chk(q, 8'h02, 8'h82);
      rd(8'hA3, q);
      chk(q, 8'h00, 8'hFF);
      // Every cause in turn: reset, then only its flag
      for (int c = 0; c < 7; c++) begin
         if (c == 1) begin
            mon_en = 1'b1;
            repeat (10) @(posedge ref_clk);
         end
         if (c inside {1, 2, 5}) wr(RCS_CAUSE_ADDR, 8'(1 << c));
         if (c == 4) wr(RCS_CAUSE_ADDR, 8'h10);
         else u_rcs_source_model.fire(c);
         repeat (3) @(posedge ref_clk);
         #1 chk({7'h00, sys_rst}, 8'h01, 8'hFF);
         wait_rst;
         rd(RCS_CAUSE_ADDR, q);
         chk(q, 8'(1 << c), 8'hFF);
      end
      // Select again while the monitor is on, then switch it off
      wr(RCS_CAUSE_ADDR, 8'h02);
      chk({7'h00, sup_sel}, 8'h01, 8'hFF);
      // Selected but monitor off: supply dip is harmless
      mon_en = 1'b0;
      u_rcs_source_model.fire(1);
      chk({7'h00, sys_rst}, 8'h00, 8'hFF);
      // Random writes never touch the status; bit four and seven stay clear
      // plain writes, no read-modify-write
      repeat (24) begin
         a = ($urandom % 2) ? RCS_CAUSE_ADDR : 8'($urandom);
         d = 8'($urandom) & 8'h6F;
         prev = {comp_en, clk_en, sup_sel};
         wr(a, d);
         q = {5'h00, comp_en, clk_en, sup_sel};
         if (a == RCS_CAUSE_ADDR) chk(q, {5'h00, d[5], d[2], d[1]}, 8'h07);
         else chk(q, {5'h00, prev}, 8'h07);
         rd(RCS_CAUSE_ADDR, q);
         chk(q, 8'h40, 8'hFF);
      end
      final_report;
   end
endmodule
